// ===== hw/pxs_slave.sv
/*
 Two-wire bus slave of an 8-bit port expander: start/stop detection, address
 match, byte reception into a write queue, byte transmission from the register
 file, acknowledge handling and the register pointer.
 Assumes rd_data is combinational from rd_addr on clk_sys, and that the serial
 pins are wired open-drain outside with a pull-up.
*/
// Functional notes
// [R1] Address 0x82 when select low, else 0x88
// [R2] Master starts with START, address, direction bit
// [R3] Matching address acknowledged in ninth bit
// [R4] Mismatch: stay released, ignore transaction
// [R5] START is SDA falling while SCL high
// [R6] Ignore everything until START is seen
// [R7] STOP is SDA rising while SCL high
// [R8] Not-acknowledge then STOP returns to idle
// [R9] STOP ends writes; no further bytes stored
// [R10] Transmitter releases after eight bits; receiver acks
// [R11] Data sampled on rising SCL
// [R12] Master changes SDA only while SCL low
// [R13] Standard and fast mode rates supported
// [R14] Read not acknowledged: stop, return idle
// [R15] Pointer advances only inside auto-increment range
// [R16] SDA only pulled low or released
// [R17] Reset returns engine idle, releases SDA
`timescale 1ns/1ns
`include "pxs_defines.svh"
module pxs_slave (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Serial link
    input wire logic scl,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe_n,
    // Address strap
    input wire logic address_select_pin,
    // Register write queue output
    output logic wr_valid,
    input wire logic wr_ready,
    output pxs_pkg::pxs_wr_t wr_data,
    // Register read port
    output logic [7:0] rd_addr,
    output logic rd_strobe,
    input wire logic [7:0] rd_data,
    // Status
    output logic busy
);

    // =====================================
    // Synchronisers and edge history
    logic scl_m, scl_s, scl_d; // Clock level, two stages and history
    logic sda_m, sda_s, sda_d; // Data level, two stages and history
    logic sel_m, sel_s; // Address strap
    logic tgl_m, tgl_s, tgl_d; // Link toggle, two stages and history
    pxs_pkg::pxs_link_t link; // Link-domain capture

    // =====================================
    // Engine state
    pxs_pkg::pxs_state_t state, next_state; // Serial engine
    logic [3:0] cnt, next_cnt; // Bits of current byte
    logic [7:0] shreg, next_shreg; // Shift register
    logic [7:0] ptr, next_ptr; // Register pointer
    logic rw, next_rw; // Direction of transaction
    logic first, next_first; // Next byte is pointer load
    logic ack_seen, next_ack_seen; // Master acknowledged
    logic pull, next_pull; // Pull data line low

    // Queue filling side
    logic q_ready, push; // Queue has room, byte offered to queue

    // Link capture on the serial clock
    pxs_link u_link (
        .scl(scl),
        .rst(rst),
        .serial_data_line_in(serial_data_line_in),
        .sample(link)
    );

    // Write queue between serial engine and register file
    pxs_fifo #(
        .WIDTH($bits(pxs_pkg::pxs_wr_t)),
        .DEPTH(`PXS_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(push),
        .in_ready(q_ready),
        .in_data({ptr, shreg}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_data)
    );

    // =====================================
    // Decoding of bus events
    wire scl_fall = scl_d & ~scl_s;
    wire scl_high = scl_s & scl_d;
    wire start_det = scl_high & sda_d & ~sda_s; // R5
    wire stop_det = scl_high & ~sda_d & sda_s; // R7
    wire rise_ev = tgl_s ^ tgl_d; // R11
    wire link_bit = link.level;
    wire byte_done = (cnt == `PXS_BITS_PER_BYTE);
    wire [7:0] own_addr = sel_s ? `PXS_ADDR_HIGH : `PXS_ADDR_LOW; // R1
    wire addr_match = (shreg[7:1] == own_addr[7:1]); // R1
    wire auto_inc = (ptr >= `PXS_AUTO_LO) && (ptr <= `PXS_AUTO_HI);
    wire [7:0] ptr_after = auto_inc ? ptr + `PXS_PTR_STEP : ptr; // R15
    wire rx_end = (state == pxs_pkg::PXS_RX) & scl_fall & byte_done;
    assign push = rx_end & ~first; // R9
    wire load_tx = scl_fall & (((state == pxs_pkg::PXS_ADDR_ACK) & rw)
        | ((state == pxs_pkg::PXS_TX_ACK) & ack_seen));

    // =====================================
    // Outputs
    assign serial_data_line_out = 1'b0; // R16
    assign serial_data_line_oe_n = ~pull; // R16
    assign rd_addr = ptr;
    assign rd_strobe = load_tx;
    assign busy = (state != pxs_pkg::PXS_IDLE);

    // =====================================
    // Two-stage synchronisers, third stage for edges
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
            {sel_m, sel_s} <= 2'h0;
            {tgl_m, tgl_s, tgl_d} <= 3'h0;
        end
        else
        begin
            {scl_m, scl_s, scl_d} <= {scl, scl_m, scl_s}; // R13
            {sda_m, sda_s, sda_d} <= {serial_data_line_in, sda_m, sda_s};
            {sel_m, sel_s} <= {address_select_pin, sel_m};
            {tgl_m, tgl_s, tgl_d} <= {link.tgl, tgl_m, tgl_s};
        end
    end

    // =====================================
    // Next-state logic of the serial engine
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_rw = rw;
        next_first = first;
        next_ack_seen = ack_seen;
        next_pull = pull;
        if (start_det)
        begin
            // Start or repeated start opens an address byte
            next_state = pxs_pkg::PXS_ADDR; // R6
            next_cnt = `PXS_CNT_RESET;
            next_pull = 1'b0;
        end
        else if (stop_det)
        begin
            // Stop ends any transfer
            next_state = pxs_pkg::PXS_IDLE; // R7 R8 R9
            next_pull = 1'b0;
        end
        else
        begin
            case (state)
                pxs_pkg::PXS_ADDR, pxs_pkg::PXS_RX:
                begin
                    // Receive bits, then answer
                    if (rise_ev && !byte_done)
                    begin
                        next_shreg = {shreg[6:0], link_bit}; // R11
                        next_cnt = cnt + `PXS_CNT_STEP;
                    end
                    else if (scl_fall && byte_done && state == pxs_pkg::PXS_ADDR)
                    begin
                        next_rw = shreg[0]; // R2
                        next_state = addr_match ? pxs_pkg::PXS_ADDR_ACK
                            : pxs_pkg::PXS_IGNORE; // R4
                        next_pull = addr_match; // R3
                    end
                    else if (rx_end)
                    begin
                        next_state = pxs_pkg::PXS_RX_ACK;
                        next_first = 1'b0;
                        if (first)
                        begin
                            next_ptr = shreg; // Pointer load
                            next_pull = 1'b1; // R10
                        end
                        else
                        begin
                            next_pull = q_ready; // Full queue answers not-acknowledge
                            next_ptr = q_ready ? ptr_after : ptr; // R15
                        end
                    end
                end
                pxs_pkg::PXS_ADDR_ACK, pxs_pkg::PXS_RX_ACK:
                begin
                    // Ninth bit ends on falling clock
                    if (scl_fall)
                    begin
                        next_cnt = `PXS_CNT_RESET;
                        next_pull = 1'b0; // R10
                        if (load_tx)
                        begin
                            next_state = pxs_pkg::PXS_TX;
                            next_shreg = rd_data;
                            next_pull = ~rd_data[7];
                        end
                        else
                        begin
                            next_state = pxs_pkg::PXS_RX;
                            next_first = (state == pxs_pkg::PXS_ADDR_ACK);
                        end
                    end
                end
                pxs_pkg::PXS_TX:
                begin
                    // Shift out, most significant bit first
                    if (rise_ev)
                    begin
                        next_cnt = cnt + `PXS_CNT_STEP;
                    end
                    else if (scl_fall && byte_done)
                    begin
                        next_state = pxs_pkg::PXS_TX_ACK;
                        next_pull = 1'b0; // R10
                        next_ptr = ptr_after; // R15
                        next_ack_seen = 1'b0;
                    end
                    else if (scl_fall)
                    begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_pull = ~shreg[6]; // R16
                    end
                end
                pxs_pkg::PXS_TX_ACK:
                begin
                    // Master answer decides continue or idle
                    if (rise_ev)
                    begin
                        next_ack_seen = ~link_bit;
                    end
                    else if (load_tx)
                    begin
                        next_state = pxs_pkg::PXS_TX;
                        next_cnt = `PXS_CNT_RESET;
                        next_shreg = rd_data;
                        next_pull = ~rd_data[7];
                    end
                    else if (scl_fall)
                    begin
                        next_state = pxs_pkg::PXS_IDLE; // R14
                    end
                end
                pxs_pkg::PXS_IGNORE:
                begin
                    // Wait for the next start or stop
                    next_pull = 1'b0; // R4
                end
                default:
                begin
                    next_state = pxs_pkg::PXS_IDLE;
                    next_pull = 1'b0;
                end
            endcase
        end
    end

    // =====================================
    // Engine registers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state <= pxs_pkg::PXS_IDLE; // R17
            pull <= 1'b0; // R17
            cnt <= `PXS_CNT_RESET;
            shreg <= 8'h00;
            ptr <= `PXS_PTR_RESET;
            {rw, first, ack_seen} <= 3'h0;
        end
        else
        begin
            state <= next_state;
            pull <= next_pull;
            cnt <= next_cnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            {rw, first, ack_seen} <= {next_rw, next_first, next_ack_seen};
        end
    end

    // =====================================
    // Checks
    a_reset_release: assert property (@(posedge clk_sys) rst |=> serial_data_line_oe_n) // R17
        else $error("Data line not released after reset");
    a_idle_released: assert property (@(posedge clk_sys) disable iff (rst) // R16
        (state == pxs_pkg::PXS_IDLE) && $past(state == pxs_pkg::PXS_IDLE)
        |-> serial_data_line_oe_n && !serial_data_line_out)
        else $error("Data line driven while idle");
    a_start_addr: assert property (@(posedge clk_sys) disable iff (rst) // R5
        start_det |=> (state == pxs_pkg::PXS_ADDR) && (cnt == 4'h0))
        else $error("Start did not open address byte");
    a_stop_idle: assert property (@(posedge clk_sys) disable iff (rst) // R7
        stop_det |=> (state == pxs_pkg::PXS_IDLE) ##1 (state == pxs_pkg::PXS_IDLE
        || state == pxs_pkg::PXS_ADDR))
        else $error("Stop did not end transfer");
    a_idle_quiet: assert property (@(posedge clk_sys) disable iff (rst) // R6
        (state == pxs_pkg::PXS_IDLE) && !start_det |=> (state == pxs_pkg::PXS_IDLE))
        else $error("Reacted without start");
    a_match_ack: assert property (@(posedge clk_sys) disable iff (rst) // R3
        (state == pxs_pkg::PXS_ADDR) && scl_fall && byte_done && addr_match && !start_det
        && !stop_det |=> !serial_data_line_oe_n && (state == pxs_pkg::PXS_ADDR_ACK))
        else $error("Matching address not acknowledged");
    a_miss_ignore: assert property (@(posedge clk_sys) disable iff (rst) // R4
        (state == pxs_pkg::PXS_IGNORE) |-> serial_data_line_oe_n && !push)
        else $error("Ignored transaction touched the bus");
    a_addr_strap: assert property (@(posedge clk_sys) disable iff (rst) // R1
        (state == pxs_pkg::PXS_ADDR_ACK) |-> $past(shreg[7:1], 1) == (sel_s ? 7'h44 : 7'h41))
        else $error("Acknowledged a foreign address");
    a_sample_rise: assert property (@(posedge clk_sys) disable iff (rst) // R11
        rise_ev && (state == pxs_pkg::PXS_RX) && !byte_done && !start_det && !stop_det
        |=> shreg[0] == $past(link_bit))
        else $error("Bit not taken from rising clock sample");
    a_nack_idle: assert property (@(posedge clk_sys) disable iff (rst) // R14
        (state == pxs_pkg::PXS_TX_ACK) && scl_fall && !ack_seen && !start_det && !stop_det
        |=> (state == pxs_pkg::PXS_IDLE) && serial_data_line_oe_n)
        else $error("Read continued after not-acknowledge");
    a_ptr_hold: assert property (@(posedge clk_sys) disable iff (rst) // R15
        push && !auto_inc |=> ptr == $past(ptr))
        else $error("Pointer moved outside auto range");
    c_addr_ack: cover property (@(posedge clk_sys) disable iff (rst)
        state == pxs_pkg::PXS_ADDR_ACK);
    c_write_push: cover property (@(posedge clk_sys) disable iff (rst) push && q_ready);
    c_read_byte: cover property (@(posedge clk_sys) disable iff (rst)
        (state == pxs_pkg::PXS_TX) ##[1:1000] (state == pxs_pkg::PXS_TX_ACK));

endmodule // pxs_slave

// ===== hw/pxs_defines.svh
/*
 Constants of the two-wire port expander slave: addresses, reset values,
 auto-increment window, byte framing and queue depth.
 Assumes inclusion by bare name from the slave module.
*/
`ifndef PXS_DEFINES_SVH
`define PXS_DEFINES_SVH

// =====================================
// Slave addresses, write form
`define PXS_ADDR_LOW 8'h82
`define PXS_ADDR_HIGH 8'h88

// =====================================
// Register pointer
`define PXS_PTR_RESET 8'h00
`define PXS_PTR_STEP 8'h01
`define PXS_AUTO_LO 8'h10
`define PXS_AUTO_HI 8'h12

// =====================================
// Byte framing
`define PXS_BITS_PER_BYTE 4'h8
`define PXS_CNT_RESET 4'h0
`define PXS_CNT_STEP 4'h1

// =====================================
// Write queue
`define PXS_FIFO_DEPTH 4

`endif

// ===== hw/pxs_pkg.sv
/*
 Types of the two-wire port expander slave: state encoding and carriers.
 Assumes the defines header is compiled alongside.
*/
package pxs_pkg;

    // =====================================
    // Serial engine states, Gray along the usual path
    typedef enum logic [2:0] {
        PXS_IDLE = 3'h0,
        PXS_ADDR = 3'h1,
        PXS_ADDR_ACK = 3'h3,
        PXS_RX = 3'h2,
        PXS_RX_ACK = 3'h6,
        PXS_TX = 3'h7,
        PXS_TX_ACK = 3'h5,
        PXS_IGNORE = 3'h4
    } pxs_state_t;

    // =====================================
    // Register write request towards the register file
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } pxs_wr_t;

    // =====================================
    // Link-side sample: toggle per clock rise plus the sampled level
    typedef struct packed {
        logic tgl;
        logic level;
    } pxs_link_t;

endpackage

// ===== hw/pxs_link.sv
/*
 Link-domain capture of the serial data line on each rising serial clock.
 Assumes the serial clock is the master's clock, which may stop between frames;
 the toggle is read in the system domain through a synchroniser, the level directly.
*/
`timescale 1ns/1ns
module pxs_link (
    // Link clock and reset
    input wire logic scl,
    input wire logic rst,
    // Serial data level
    input wire logic serial_data_line_in,
    // Sample towards the system domain
    output pxs_pkg::pxs_link_t sample
);

    // =====================================
    // Capture on rising clock; toggle marks each new bit
    always_ff @(posedge scl or posedge rst)
    begin
        if (rst)
        begin
            sample <= '0;
        end
        else
        begin
            sample.level <= serial_data_line_in; // R11
            sample.tgl <= ~sample.tgl;
        end
    end

endmodule // pxs_link

// ===== hw/pxs_fifo.sv
/*
 Small synchronous FIFO with valid and ready on both sides.
 Assumes one clock and a synchronous active-high reset; DEPTH a power of two.
*/
`timescale 1ns/1ns
module pxs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage
    logic [AW-1:0] wr_ptr; // Next write slot
    logic [AW-1:0] rd_ptr; // Next read slot
    logic [AW:0] count; // Words held

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count < (AW+1)'(DEPTH)); // Room while below depth
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // =====================================
    // Storage write
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // =====================================
    // Pointers and fill level
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule // pxs_fifo

// ===== tb/pxs_master.sv
/*
 Two-wire bus master model: drives the serial clock and pulls the data wire low.
 Assumes the bench resolves the wire with a pull-up and feeds it back as sda.
*/
`timescale 1ns/1ns
module pxs_master (
    // Wire drive
    output logic scl,
    output logic pull,
    // Resolved wire level
    input wire logic sda
);
    // =====================================
    // Half period of the serial clock in ns
    int half = 1300;

    // Idle bus: clock high and still, wire released
    initial
    begin
        scl = 1'b1;
        pull = 1'b0;
    end

    // START, also repeated START from clock low
    task automatic start();
        pull = 1'b0;
        #(half);
        scl = 1'b1;
        #(half);
        pull = 1'b1;
        #(half);
        scl = 1'b0;
    endtask

    // STOP from clock low, then bus free time
    task automatic stop();
        #(half / 2);
        pull = 1'b1;
        #(half / 2);
        scl = 1'b1;
        #(half);
        pull = 1'b0;
        #(half);
    endtask

    // One bit: data changed mid-low, sampled mid-high
    task automatic bit_io(input logic low, output logic seen);
        #(half / 2);
        pull = low;
        #(half / 2);
        scl = 1'b1;
        #(half / 2);
        seen = sda;
        #(half / 2);
        scl = 1'b0;
    endtask

    // Send n bits MSB first; with eight, release and read the ack
    task automatic shift(input logic [7:0] d, input int n, output logic ack);
        logic s;
        ack = 1'b1;
        for (int i = 0; i < n; i++)
            bit_io(~d[7 - i], s);
        if (n == 8)
            bit_io(1'b0, ack);
    endtask

    // Receive a byte, then ack or not-acknowledge it
    task automatic recv(input logic not_acknowledge, output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++)
            bit_io(1'b0, d[7 - i]);
        bit_io(~not_acknowledge, s);
    endtask

    // Clocked bits with no START in front, then back to idle
    task automatic noise(input logic [7:0] d, output logic ack);
        scl = 1'b0;
        #(half);
        shift(d, 8, ack);
        #(half);
        scl = 1'b1;
        #(half);
    endtask
endmodule // pxs_master

// ===== tb/test_pxs_slave.sv
/*
 Self-checking bench of the two-wire slave with a master model on the wire.
 Assumes a pull-up on the data wire and a register file answering rd_addr at once.
*/
`timescale 1ns/1ns
module test_pxs_slave;
    // =====================================
    // Stimulus and observed signals
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic address_select_pin = 1'b0;
    logic wr_ready = 1'b0;
    logic scl, pull, sda, sdo, oe_n, wr_valid, rd_strobe, busy;
    logic [7:0] rd_addr, rd_data;
    pxs_pkg::pxs_wr_t wr_data;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int strobes = 0;

    // Register file contents as a function of address
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        return {a[3:0], ~a[7:4]};
    endfunction

    // Open-drain wire with pull-up
    assign sda = !(pull || !oe_n);
    assign rd_data = exp_rd(rd_addr);

    // System clock, 50 ns
    initial
    forever #25 clk_sys = ~clk_sys;

    // Hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miscompares++;
            summarize();
        end
    end

    // Count register loads where the strobe has settled
    always @(negedge clk_sys)
    begin
        if (rd_strobe === 1'b1)
            strobes++;
    end

    pxs_slave uut (
        .clk_sys(clk_sys), .rst(rst), .scl(scl), .serial_data_line_in(sda),
        .serial_data_line_out(sdo), .serial_data_line_oe_n(oe_n),
        .address_select_pin(address_select_pin), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .rd_addr(rd_addr),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .busy(busy)
    );
    pxs_master u_master (.scl(scl), .pull(pull), .sda(sda));

    // =====================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Take one queued write and compare it
    task automatic pop(input logic [15:0] exp);
        int n = 0;
        tick(1);
        while (wr_valid !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        check(wr_data, exp);
        wr_ready = 1'b1;
        tick(1);
        wr_ready = 1'b0;
    endtask

    // START, address byte, pointer byte, both acknowledged
    task automatic open(input logic [7:0] addr, input logic [7:0] ptr);
        logic a;
        u_master.start();
        u_master.shift(addr, 8, a);
        check(16'(a), 16'h0);
        u_master.shift(ptr, 8, a);
        check(16'(a), 16'h0);
    endtask

    task automatic summarize();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // =====================================
    // Scenarios
    task automatic t_noise();
        logic a;
        u_master.noise(8'h82, a);
        check(16'(a), 16'h1);
        check(16'(busy), 16'h0);
        $display("t_noise done");
    endtask

    task automatic t_write();
        logic a;
        open(8'h82, 8'h10);
        u_master.shift(8'h3C, 8, a);
        check(16'(a), 16'h0);
        u_master.shift(8'h5A, 8, a);
        check(16'(a), 16'h0);
        check(16'(rd_addr), 16'h12);
        u_master.stop();
        tick(8);
        check(16'(busy), 16'h0);
        pop(16'h103C);
        pop(16'h115A);
        check(16'(wr_valid), 16'h0);
        check(16'(sdo), 16'h0);
        $display("t_write done");
    endtask

    task automatic t_reset();
        logic a;
        u_master.start();
        u_master.shift(8'h82, 4, a);
        tick(1);
        rst = 1'b1;
        tick(16);
        check(16'(busy), 16'h0);
        check(16'(oe_n), 16'h1);
        rst = 1'b0;
        tick(4);
        u_master.stop();
        $display("t_reset done");
    endtask

    task automatic t_ignore();
        logic a;
        u_master.start();
        u_master.shift(8'h88, 8, a);
        check(16'(a), 16'h1);
        u_master.shift(8'h20, 8, a);
        check(16'(a), 16'h1);
        u_master.stop();
        tick(8);
        check(16'(wr_valid), 16'h0);
        check(16'(busy), 16'h0);
        $display("t_ignore done");
    endtask

    task automatic t_read(input logic [7:0] ptr, input logic [7:0] step);
        logic [7:0] d;
        logic a;
        int s0 = strobes;
        open(8'h82, ptr);
        u_master.start();
        u_master.shift(8'h83, 8, a);
        check(16'(a), 16'h0);
        u_master.recv(1'b0, d);
        check(16'(d), 16'(exp_rd(ptr)));
        u_master.recv(1'b0, d);
        check(16'(d), 16'(exp_rd(ptr + step)));
        u_master.recv(1'b1, d);
        check(16'(d), 16'(exp_rd(ptr + step + step)));
        tick(10);
        check(16'(busy), 16'h0);
        u_master.stop();
        tick(8);
        check(16'(oe_n), 16'h1);
        check(16'(strobes - s0), 16'h3);
        $display("t_read done");
    endtask

    task automatic t_full();
        logic a;
        open(8'h82, 8'h20);
        for (int i = 0; i < 5; i++)
        begin
            u_master.shift(8'hC0 + 8'(i), 8, a);
            check(16'(a), (i < 4) ? 16'h0 : 16'h1);
        end
        u_master.stop();
        check(16'(rd_addr), 16'h20);
        for (int i = 0; i < 4; i++)
            pop(16'h20C0 + 16'(i));
        tick(2);
        check(16'(wr_valid), 16'h0);
        $display("t_full done");
    endtask

    task automatic t_partial();
        logic a;
        open(8'h82, 8'h40);
        u_master.shift(8'hF0, 4, a);
        u_master.stop();
        tick(8);
        check(16'(wr_valid), 16'h0);
        $display("t_partial done");
    endtask

    task automatic t_select();
        logic a;
        tick(1);
        address_select_pin = 1'b1;
        tick(4);
        u_master.half = 5000;
        open(8'h88, 8'h30);
        u_master.shift(8'h99, 8, a);
        check(16'(a), 16'h0);
        u_master.stop();
        pop(16'h3099);
        u_master.start();
        u_master.shift(8'h82, 8, a);
        check(16'(a), 16'h1);
        u_master.stop();
        u_master.half = 1300;
        $display("t_select done");
    endtask

    // =====================================
    // Main sequence
    initial
    begin
        tick(16);
        rst = 1'b0;
        tick(4);
        t_noise();
        t_write();
        t_reset();
        t_ignore();
        t_read(8'h10, 8'h01);
        t_read(8'h05, 8'h00);
        t_full();
        t_partial();
        t_select();
        summarize();
    end
endmodule // test_pxs_slave
